/* src/travel_pulse_monitor_regs.svh */
// Summary of operation
// - Enable input turns pulse supervision on or off
// - Check only at medium or rated speed
// - 100 ms without pulse forces low speed
// - Stop at zone or 5 s, then out
// - Flush halt keeps operation, logs warning entry
// - Repeat fault next travel ends operation permanently
// - Non-flush stop after fault ends operation
// - No supervision during assembly operation
// - Only reset clears out-of-operation state
`ifndef TRAVEL_PULSE_MONITOR_REGS_SVH
`define TRAVEL_PULSE_MONITOR_REGS_SVH
`define CLK_PERIOD_NS 100
`define GAP_TIME_MS 100
`define GAP_CYCLES ((`GAP_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define STOP_TIME_S 5
`define STOP_CYCLES ((`STOP_TIME_S * 1000) * (1000000 / `CLK_PERIOD_NS))
`define CODE_NONE 2'h0
`define CODE_WARN 2'h1
`define CODE_FINAL 2'h2
`define CODE_STOP 2'h3
`endif

/* src/travel_pulse_monitor_pkg.sv */
package travel_pulse_monitor_pkg;
   // Speed stage reported by the drive
   typedef enum logic [1:0] {
      SPD_STILL, SPD_LOW, SPD_MEDIUM, SPD_RATED
   } speed_t;
   // Fault entry handed to the error memory
   typedef struct packed {
      logic valid;
      logic [1:0] code;
   } fault_entry_t;
   // Commands to the drive
   typedef struct packed {
      logic force_low;
      logic emerg_stop;
   } drive_cmd_t;
endpackage

/* src/travel_pulse_monitor.sv */
`timescale 1ns/1ps
`include "travel_pulse_monitor_regs.svh"
module travel_pulse_monitor #(
   // Timing counts in clock cycles; a bench may shorten them
   parameter int GAP_N = `GAP_CYCLES,
   parameter int STOP_N = `STOP_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Configuration and operating mode
   input wire logic mon_enable,
   input wire logic assembly_mode,
   // Car and shaft status
   input wire logic count_pulse,
   input wire logic zone,
   input wire travel_pulse_monitor_pkg::speed_t speed,
   input wire logic travelling,
   input wire logic flush_stop,
   // Drive commands and error memory
   output travel_pulse_monitor_pkg::drive_cmd_t drive_cmd_ff,
   output travel_pulse_monitor_pkg::fault_entry_t fault_entry_ff,
   output logic out_of_op_ff
);
   import travel_pulse_monitor_pkg::*;

   // Supervisor phases
   typedef enum logic [1:0] {
      ST_WATCH, ST_SLOW, ST_HALT, ST_OUT
   } phase_t;

   phase_t phase_ff;
   logic pulse_d_ff;   // Previous pulse level for edge detection
   logic [20:0] gap_ff;   // Missing-pulse interval counter
   logic [25:0] stop_ff;   // Time since detection
   logic warned_ff;   // Warning recorded, next travel armed
   logic travel_d_ff;   // Previous travelling level
   logic check;
   logic pulse_edge;
   logic gap_hit;
   logic stop_due;

   // Checking runs only enabled, outside assembly, at fast speeds
   assign check = mon_enable && !assembly_mode && travelling &&
      (speed == SPD_MEDIUM || speed == SPD_RATED);
   // Pulse line rests low, so a cleared history gives no false edge
   assign pulse_edge = count_pulse && !pulse_d_ff;
   assign gap_hit = check && (gap_ff == 21'(GAP_N - 1));
   assign stop_due = zone || (stop_ff == 26'(STOP_N - 1));

   // Edge and travel-end history
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pulse_d_ff <= 1'b0;
         travel_d_ff <= 1'b0;
      end else begin
         pulse_d_ff <= count_pulse;
         travel_d_ff <= travelling;
      end
   end

   // Interval timer; cleared while not checking or on a pulse edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_ff <= 21'h0;
      end else if (!check || pulse_edge || phase_ff != ST_WATCH) begin
         gap_ff <= 21'h0;
      end else begin
         gap_ff <= gap_ff + 21'h1;
      end
   end

   // Stop window counter runs only while slowed down
   // Wide enough for the full 5 s window at the system clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stop_ff <= 26'h0;
      end else if (phase_ff == ST_SLOW) begin
         stop_ff <= stop_ff + 26'h1;
      end else begin
         stop_ff <= 26'h0;
      end
   end

   // Fault sequencing and error memory entries
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_ff <= ST_WATCH;
         warned_ff <= 1'b0;
         drive_cmd_ff <= '0;
         fault_entry_ff <= '0;
         out_of_op_ff <= 1'b0;
      end else begin
         fault_entry_ff.valid <= 1'b0;
         case (phase_ff)
            ST_WATCH: begin
               if (gap_hit) begin
                  drive_cmd_ff.force_low <= 1'b1;
                  if (warned_ff) begin
                     // Second fault after a warning ends operation
                     phase_ff <= ST_OUT;
                     drive_cmd_ff.emerg_stop <= 1'b1;
                     out_of_op_ff <= 1'b1;
                     fault_entry_ff <= '{1'b1, `CODE_FINAL};
                  end else begin
                     phase_ff <= ST_SLOW;
                  end
               end else if (travel_d_ff && !travelling) begin
                  // A clean travel disarms the warning
                  warned_ff <= 1'b0;
               end
            end
            ST_SLOW: begin
               if (!travelling && flush_stop) begin
                  // Flush landing: keep running, log a warning
                  phase_ff <= ST_WATCH;
                  drive_cmd_ff.force_low <= 1'b0;
                  warned_ff <= 1'b1;
                  fault_entry_ff <= '{1'b1, `CODE_WARN};
               end else if (stop_due || !travelling) begin
                  phase_ff <= ST_HALT;
                  drive_cmd_ff.emerg_stop <= 1'b1;
                  out_of_op_ff <= 1'b1;
                  fault_entry_ff <= '{1'b1, `CODE_STOP};
               end
            end
            ST_HALT: begin
               // Stopped off flush: final code, permanent
               phase_ff <= ST_OUT;
               fault_entry_ff <= '{1'b1, `CODE_FINAL};
            end
            ST_OUT: begin
               // Latched until reset
               out_of_op_ff <= 1'b1;
            end
            default: begin
               phase_ff <= ST_OUT;
            end
         endcase
      end
   end

   // Supervision rules, checked at the outputs where possible
   property p_gap_slow;
      @(posedge clk) disable iff (!nrst)
      gap_hit |=> drive_cmd_ff.force_low;
   endproperty
   a_gap_slow: assert property (p_gap_slow)
      else $error("low speed not forced after pulse gap");

   property p_no_check;
      @(posedge clk) disable iff (!nrst)
      !check |=> gap_ff == 21'h0;
   endproperty
   a_no_check: assert property (p_no_check)
      else $error("gap timer not cleared while idle");

   property p_disabled;
      @(posedge clk) disable iff (!nrst)
      (!mon_enable || assembly_mode) && !drive_cmd_ff.force_low
         |=> !drive_cmd_ff.force_low;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("fault while supervision off");

   property p_speed;
      @(posedge clk) disable iff (!nrst)
      (speed == SPD_LOW || speed == SPD_STILL) && !drive_cmd_ff.force_low
         |=> !drive_cmd_ff.force_low;
   endproperty
   a_speed: assert property (p_speed)
      else $error("fault at unchecked speed");

   property p_assembly;
      @(posedge clk) disable iff (!nrst)
      assembly_mode |=> gap_ff == 21'h0;
   endproperty
   a_assembly: assert property (p_assembly)
      else $error("timer ran in assembly mode");

   property p_zone_stop;
      @(posedge clk) disable iff (!nrst)
      (phase_ff == ST_SLOW && zone && travelling)
         |=> drive_cmd_ff.emerg_stop && out_of_op_ff;
   endproperty
   a_zone_stop: assert property (p_zone_stop)
      else $error("no emergency stop at zone");

   property p_stop_time;
      @(posedge clk) disable iff (!nrst)
      (phase_ff == ST_SLOW && travelling && stop_ff == 26'(STOP_N - 1))
         |=> drive_cmd_ff.emerg_stop && out_of_op_ff;
   endproperty
   a_stop_time: assert property (p_stop_time)
      else $error("no emergency stop after stop window");

   property p_flush;
      @(posedge clk) disable iff (!nrst)
      (phase_ff == ST_SLOW && !travelling && flush_stop)
         |=> !out_of_op_ff && fault_entry_ff.code == `CODE_WARN;
   endproperty
   a_flush: assert property (p_flush)
      else $error("flush halt mishandled");

   property p_repeat;
      @(posedge clk) disable iff (!nrst)
      (gap_hit && warned_ff && phase_ff == ST_WATCH)
         |=> out_of_op_ff && fault_entry_ff.code == `CODE_FINAL;
   endproperty
   a_repeat: assert property (p_repeat)
      else $error("repeat fault not final");

   property p_halt_final;
      @(posedge clk) disable iff (!nrst)
      phase_ff == ST_HALT
         |=> fault_entry_ff.valid && fault_entry_ff.code == `CODE_FINAL;
   endproperty
   a_halt_final: assert property (p_halt_final)
      else $error("final code missing after stop");

   property p_sticky;
      @(posedge clk) disable iff (!nrst)
      out_of_op_ff |=> out_of_op_ff;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("out of operation cleared without reset");
endmodule

/* testbench/shaft_encoder_model.sv */
`timescale 1ns/1ps
module shaft_encoder_model (
   // Clock and shaft motion
   input wire logic clk,
   input wire logic run,
   // Counting pulse to the monitor
   output logic count_pulse
);
   logic [3:0] div_ff = 4'h0; // Pulse spacing
   // Pulses only while the shaft turns; the line rests low when stopped
   always @(posedge clk) begin
      div_ff <= div_ff + 4'h1;
      count_pulse <= run & div_ff[3];
   end
endmodule

/* testbench/travel_pulse_monitor_tb.sv */
`timescale 1ns/1ps
module travel_pulse_monitor_tb;
   // Shortened timing counts keep the run brief
   localparam int GAP = 400;
   localparam int STOP = 3000;
   import travel_pulse_monitor_pkg::*;
   logic clk, nrst, mon_enable, assembly_mode, zone, travelling;
   logic flush_stop, run, count_pulse, out_of_op_ff;
   speed_t speed;
   drive_cmd_t drive_cmd_ff;
   fault_entry_t fault_entry_ff;
   logic [1:0] codes[$]; // Error memory contents
   int bad_count, compares;
   travel_pulse_monitor #(.GAP_N(GAP), .STOP_N(STOP)) dut (.clk(clk),
      .nrst(nrst),
      .mon_enable(mon_enable), .assembly_mode(assembly_mode),
      .count_pulse(count_pulse), .zone(zone), .speed(speed),
      .travelling(travelling), .flush_stop(flush_stop),
      .drive_cmd_ff(drive_cmd_ff), .fault_entry_ff(fault_entry_ff),
      .out_of_op_ff(out_of_op_ff));
   shaft_encoder_model enc (.clk(clk), .run(run),
      .count_pulse(count_pulse));
   // Clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Entries stand one cycle only, so log each mid-cycle while settled
   always @(negedge clk) begin
      if (fault_entry_ff.valid === 1'b1) codes.push_back(fault_entry_ff.code);
   end
   // Hang guard, well beyond the roughly 8k cycles the tests take
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run();
   end
   task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Output state as force_low, emerg_stop, out_of_op
   function automatic logic [3:0] st();
      return {1'b0, drive_cmd_ff, out_of_op_ff};
   endfunction
   task automatic do_reset();
      nrst = 1'b0;
      step(12);
      nrst = 1'b1;
      codes.delete();
      check("reset", st(), 4'h0);
   endtask
   // Checked travel at rated speed with healthy pulses
   task automatic travel();
      {zone, flush_stop, assembly_mode} = 3'h0;
      {travelling, mon_enable, run} = 3'h7;
      speed = SPD_RATED;
      step(100);
   endtask
   // Pulses vanish; margin covers encoder phase and input sync
   task automatic gap();
      run = 1'b0;
      step(GAP - 50);
      check("early", st(), 4'h0);
      step(100);
   endtask
   task automatic t_quiet();
      travel();
      run = 1'b0;
      for (int i = 0; i < 3; i++) begin
         mon_enable = (i != 0);
         assembly_mode = (i == 1);
         speed = (i == 2) ? SPD_LOW : SPD_RATED;
         step(GAP + 100);
         check("idle", st(), 4'h0);
      end
      {assembly_mode, mon_enable} = 2'h1;
      speed = SPD_RATED;
      step(GAP * 3 / 5);
      run = 1'b1;
      step(100);
      run = 1'b0;
      step(GAP * 3 / 5);
      speed = SPD_LOW;
      step(10);
      speed = SPD_RATED;
      step(GAP * 3 / 5);
      check("restart", st(), 4'h0);
      {travelling, flush_stop} = 2'h1;
      step(10);
      check("clean", 4'(codes.size()), 4'h0);
   endtask
   task automatic t_warn();
      travel();
      gap();
      check("slow", st(), 4'h4);
      {travelling, flush_stop} = 2'h1;
      step(5);
      check("flush", st(), 4'h0);
      check("warn", {2'h0, codes[$]}, 4'h1);
   endtask
   task automatic t_repeat();
      travel();
      gap();
      check("final", st() & 4'h3, 4'h3);
      check("fcode", {2'h0, codes[$]}, 4'h2);
      {travelling, flush_stop, mon_enable, zone} = 4'h5;
      step(20);
      check("sticky", st() & 4'h3, 4'h3);
   endtask
   task automatic t_zone();
      travel();
      gap();
      step(100);
      check("nozone", st(), 4'h4);
      zone = 1'b1;
      step(3);
      check("stop", st() & 4'h3, 4'h3);
      check("n", 4'(codes.size()), 4'h2);
      check("c0", {2'h0, codes[0]}, 4'h3);
      check("c1", {2'h0, codes[1]}, 4'h2);
   endtask
   // No zone arrives at medium speed: the stop window ends the travel
   task automatic t_timeout();
      travel();
      speed = SPD_MEDIUM;
      gap();
      step(STOP - 100);
      check("window", st(), 4'h4);
      step(100);
      check("tstop", st(), 4'h7);
      check("tn", 4'(codes.size()), 4'h2);
      check("t0", {2'h0, codes[0]}, 4'h3);
      check("t1", {2'h0, codes[1]}, 4'h2);
   endtask
   task automatic complete_run();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      {nrst, mon_enable, assembly_mode, zone} = 4'h0;
      {travelling, flush_stop, run} = 3'h0;
      speed = SPD_STILL;
      do_reset();
      t_quiet();
      t_warn();
      t_repeat();
      do_reset();
      t_zone();
      do_reset();
      t_timeout();
      complete_run();
   end
endmodule
